/* File: rtl/asp_pkg.sv */
package asp_pkg;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_HZ = 50000000;
   localparam int FAULT_FLASH_MS = 250;
   localparam int FAULT_FLASH_CYC = FAULT_FLASH_MS * (CLK_HZ / 1000);
   localparam int BLIP_MS = 50;
   localparam int BLIP_CYC = BLIP_MS * (CLK_HZ / 1000);
   localparam int DIR_HOLD_MS = 500;
   localparam int DIR_HOLD_CYC = DIR_HOLD_MS * (CLK_HZ / 1000);
   localparam int CNT_W = 32;
   localparam int LOAD_W = 8;
   localparam logic [LOAD_W-1:0] LOAD_CYC = 8'h10;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int DIAG_W = 16;
   localparam int DIAG_PROX_BIT = 9;
   localparam int DIAG_TRACK_BIT = 10;
   localparam int AXES = 2;

   // ----------------------------------------
   // axis indicator and input modes
   // ----------------------------------------
   typedef enum logic [1:0] {
      IND_NORMAL,
      IND_STANDSTILL,
      IND_OVERSPEED,
      IND_FAULT_BLIP
   } asp_ind_type;

   typedef enum logic [1:0] {
      MODE_ENCODER,
      MODE_TWO_PROX,
      MODE_MIXED
   } asp_mode_type;

   typedef struct packed {
      logic trackA;
      logic trackB;
      logic prox;
   } asp_act_type;

   typedef struct packed {
      logic standstill;
      logic speedOk;
      logic diagProx;
      logic diagTrack;
      logic errEntry;
   } asp_res_type;

endpackage : asp_pkg

/* File: rtl/asp_monitor.sv */
// Operation
// - configuration is loaded before any monitoring starts
// - operational only with own and controller supply/run indicators steady
// - activity flags are 1 while pulses seen, 0 otherwise
// - none active: standstill; all active: rotation; no diagnostics
// - prox only, shearpin off: outputs 1, diag bit 9, no entry
// - prox only, shearpin on: outputs 0, diag bit 9, entry logged
// - track B only: outputs 1, no diagnostics
// - track B plus prox: clear standstill, bit 10, entry logged
// - track A only: outputs 1, no diagnostics
// - track A plus prox: clear standstill, bit 10, entry logged
// - both tracks, no prox: clear standstill, bit 9, entry logged
// - rotating: speed output 1 until overspeed limit exceeded
// - direction output may be wrong about 500 ms after faults
// - fault indicator steady on external fault, encoder indicators flash
// - fault indicator flashes on internal fault
// - axis indicator blips on encoder or wiring fault
// - axis indicator shows normal, standstill and overspeed
// - encoder port indicator lit while encoder correctly connected
// - proximity indicator lit while its input is energised
module asp_monitor (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic cfgValid,
   input wire logic [1:0] axisMode0,
   input wire logic [1:0] axisMode1,
   input wire logic shearpinEnable,
   input wire logic [31:0] activityWindow,
   input wire logic [asp_pkg::AXES-1:0] encTrackA,
   input wire logic [asp_pkg::AXES-1:0] encTrackB,
   input wire logic [asp_pkg::AXES-1:0] encConnected,
   input wire logic [asp_pkg::AXES-1:0] overspeed,
   input wire logic [asp_pkg::AXES-1:0] dirRaw,
   input wire logic axis_one_prox_input_a,
   input wire logic axis_one_prox_input_b,
   input wire logic axis_two_prox_input_a,
   input wire logic axis_two_prox_input_b,
   input wire logic internalFault,
   input wire logic ctrlSupplyOk,
   input wire logic ctrlRunOk,
   output logic monitorActive,
   output logic operational,
   output logic [asp_pkg::AXES-1:0] standstillOut,
   output logic [asp_pkg::AXES-1:0] speedOut,
   output logic [asp_pkg::AXES-1:0] directionOut,
   output logic [asp_pkg::AXES-1:0] directionValid,
   output logic [asp_pkg::DIAG_W-1:0] diagWord0,
   output logic [asp_pkg::DIAG_W-1:0] diagWord1,
   output logic [asp_pkg::AXES-1:0] errStackPush,
   output logic [asp_pkg::AXES-1:0] safeShutdown,
   output logic powerLed,
   output logic faultLed,
   output logic [1:0] axis_one_state_indicator,
   output logic [1:0] axis_two_state_indicator,
   output logic axis_one_encoder_port,
   output logic axis_two_encoder_port,
   output logic [3:0] proxLed
);
   localparam int AXES_W = asp_pkg::AXES;

   // ----------------------------------------
   // configuration load and readiness
   // ----------------------------------------
   logic [asp_pkg::LOAD_W-1:0] loadCnt_r;
   logic loaded_r;
   wire loadDone = cfgValid && (loadCnt_r == asp_pkg::LOAD_CYC);

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         loadCnt_r <= 8'h00;
         loaded_r <= 1'b0;
      end else begin
         if (cfgValid && !loaded_r && loadCnt_r != asp_pkg::LOAD_CYC)
            loadCnt_r <= loadCnt_r + 8'h01;
         if (loadDone)
            loaded_r <= 1'b1;
      end
   end

   // ----------------------------------------
   // flash timebase
   // ----------------------------------------
   logic [asp_pkg::CNT_W-1:0] flashCnt_r;
   logic flash_r;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         flashCnt_r <= '0;
         flash_r <= 1'b0;
      end else if (flashCnt_r == asp_pkg::CNT_W'(asp_pkg::FAULT_FLASH_CYC - 1)) begin
         flashCnt_r <= '0;
         flash_r <= ~flash_r;
      end else begin
         flashCnt_r <= flashCnt_r + 1'b1;
      end
   end
   // brief flash: lit only during the first part of each on phase of flash_r
   wire blip = flash_r && (flashCnt_r < asp_pkg::CNT_W'(asp_pkg::BLIP_CYC));

   wire [1:0] modeArr [AXES_W];
   assign modeArr[0] = axisMode0;
   assign modeArr[1] = axisMode1;
   wire [AXES_W-1:0] proxA = {axis_two_prox_input_a, axis_one_prox_input_a};
   wire [AXES_W-1:0] proxB = {axis_two_prox_input_b, axis_one_prox_input_b};
   logic [AXES_W-1:0] extFault;
   logic [1:0] indState [AXES_W];
   logic [AXES_W-1:0] encLed;

   // ----------------------------------------
   // per-axis plausibility
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < AXES_W; g++) begin : gAxis
         wire isTwoProx = modeArr[g] == asp_pkg::MODE_TWO_PROX;
         wire isMixed = modeArr[g] == asp_pkg::MODE_MIXED;
         wire srcA = isTwoProx ? proxA[g] : encTrackA[g];
         wire srcB = isTwoProx ? proxB[g] : encTrackB[g];
         wire srcP = isMixed ? proxA[g] : 1'b0;
         wire [2:0] src = {srcA, srcB, srcP};

         logic [2:0] prev_r;
         logic [asp_pkg::CNT_W-1:0] win_r [3];
         asp_pkg::asp_act_type act_r;
         logic [2:0] actNxt;
         for (genvar k = 0; k < 3; k++) begin : gIn
            wire edgeSeen = src[k] ^ prev_r[k];
            wire expired = win_r[k] == '0;
            always_ff @(posedge mclk or negedge reset_n) begin
               if (!reset_n)
                  win_r[k] <= '0;
               else if (edgeSeen)
                  win_r[k] <= activityWindow;
               else if (!expired)
                  win_r[k] <= win_r[k] - 1'b1;
            end
            assign actNxt[k] = edgeSeen || !expired;
         end

         always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
               prev_r <= 3'h0;
               act_r <= '0;
            end else begin
               prev_r <= src;
               act_r <= actNxt;
            end
         end

         // only the mixed mode has the full three-input check
         wire a = act_r.trackA;
         wire b = act_r.trackB;
         wire p = isMixed ? act_r.prox : (a & b);
         asp_pkg::asp_res_type res;
         always_comb begin
            // defaults covering states A and H
            res.standstill = !(a || b || p);
            res.speedOk = 1'b1;
            res.diagProx = 1'b0;
            res.diagTrack = 1'b0;
            res.errEntry = 1'b0;
            case ({a, b, p})
               3'b001: begin
                  res.diagProx = 1'b1;
                  res.standstill = 1'b1;
                  if (shearpinEnable) begin
                     res.standstill = 1'b0;
                     res.speedOk = 1'b0;
                     res.errEntry = 1'b1;
                  end
               end
               3'b010: res.standstill = 1'b1;
               3'b100: res.standstill = 1'b1;
               3'b011, 3'b101: begin
                  // track A fault, track B fault
                  res.standstill = 1'b0;
                  res.diagTrack = 1'b1;
                  res.errEntry = 1'b1;
                  res.speedOk = !overspeed[g];
               end
               3'b110: begin
                  res.standstill = 1'b0;
                  res.diagProx = 1'b1;
                  res.errEntry = 1'b1;
                  res.speedOk = !overspeed[g];
               end
               3'b111: res.speedOk = !overspeed[g];
               default: ;
            endcase
         end

         logic errPrev_r;
         logic [asp_pkg::CNT_W-1:0] dirHold_r;
         always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
               standstillOut[g] <= 1'b0;
               speedOut[g] <= 1'b0;
               errStackPush[g] <= 1'b0;
               safeShutdown[g] <= 1'b0;
               errPrev_r <= 1'b0;
               directionOut[g] <= 1'b0;
               directionValid[g] <= 1'b0;
               dirHold_r <= '0;
               extFault[g] <= 1'b0;
               encLed[g] <= 1'b0;
            end else begin
               standstillOut[g] <= loaded_r & res.standstill;
               speedOut[g] <= loaded_r & res.speedOk;
               errPrev_r <= loaded_r & res.errEntry;
               errStackPush[g] <= loaded_r & res.errEntry & !errPrev_r;
               if (loaded_r && res.errEntry)
                  safeShutdown[g] <= 1'b1;
               extFault[g] <= loaded_r & res.errEntry;
               if ((loaded_r && res.errEntry) || internalFault)
                  dirHold_r <= asp_pkg::CNT_W'(asp_pkg::DIR_HOLD_CYC);
               else if (dirHold_r != '0)
                  dirHold_r <= dirHold_r - 1'b1;
               directionOut[g] <= dirRaw[g];
               directionValid[g] <= loaded_r && dirHold_r == '0;
               encLed[g] <= encConnected[g] && !isTwoProx;
            end
         end

         assign indState[g] = res.errEntry ? asp_pkg::IND_FAULT_BLIP :
                              res.standstill ? asp_pkg::IND_STANDSTILL :
                              !res.speedOk ? asp_pkg::IND_OVERSPEED : asp_pkg::IND_NORMAL;
      end
   endgenerate

   // ----------------------------------------
   // diagnostics and indicators
   // ----------------------------------------
   wire [asp_pkg::DIAG_W-1:0] diagNxt0 =
      (asp_pkg::DIAG_W'(gAxis[0].res.diagProx) << asp_pkg::DIAG_PROX_BIT) |
      (asp_pkg::DIAG_W'(gAxis[0].res.diagTrack) << asp_pkg::DIAG_TRACK_BIT);
   wire [asp_pkg::DIAG_W-1:0] diagNxt1 =
      (asp_pkg::DIAG_W'(gAxis[1].res.diagProx) << asp_pkg::DIAG_PROX_BIT) |
      (asp_pkg::DIAG_W'(gAxis[1].res.diagTrack) << asp_pkg::DIAG_TRACK_BIT);
   // steady on external, flashing on internal
   wire faultNxt = internalFault ? flash_r : (|extFault);
   wire [1:0] ind0Nxt = (indState[0] == asp_pkg::IND_FAULT_BLIP) ? {1'b1, blip} : indState[0];
   wire [1:0] ind1Nxt = (indState[1] == asp_pkg::IND_FAULT_BLIP) ? {1'b1, blip} : indState[1];

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         diagWord0 <= '0;
         diagWord1 <= '0;
         monitorActive <= 1'b0;
         operational <= 1'b0;
         powerLed <= 1'b0;
         faultLed <= 1'b0;
         axis_one_state_indicator <= 2'h0;
         axis_two_state_indicator <= 2'h0;
         axis_one_encoder_port <= 1'b0;
         axis_two_encoder_port <= 1'b0;
         proxLed <= 4'h0;
      end else begin
         diagWord0 <= loaded_r ? diagNxt0 : '0;
         diagWord1 <= loaded_r ? diagNxt1 : '0;
         monitorActive <= loaded_r;
         powerLed <= 1'b1;
         operational <= loaded_r && ctrlSupplyOk && ctrlRunOk && !internalFault;
         faultLed <= faultNxt;
         axis_one_state_indicator <= ind0Nxt;
         axis_two_state_indicator <= ind1Nxt;
         axis_one_encoder_port <= extFault[0] ? flash_r : encLed[0];
         axis_two_encoder_port <= extFault[1] ? flash_r : encLed[1];
         proxLed <= {axis_two_prox_input_b, axis_two_prox_input_a,
                     axis_one_prox_input_b, axis_one_prox_input_a};
      end
   end

endmodule : asp_monitor

/* File: dv/asp_monitor_props.sv */
module asp_monitor_props (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic cfgValid,
   input wire logic ctrlSupplyOk,
   input wire logic [1:0] encConnected,
   input wire logic monitorActive,
   input wire logic operational,
   input wire logic powerLed,
   input wire logic [1:0] standstillOut,
   input wire logic [1:0] errStackPush,
   input wire logic [1:0] safeShutdown,
   input wire logic [15:0] diagWord0,
   input wire logic [1:0] axis_one_state_indicator,
   input wire logic axis_one_encoder_port
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   AST_LOAD_WAIT: assert property ($rose(cfgValid) |-> !monitorActive [*8])
      else $error("monitor active too soon after load");
   AST_POWER_ON: assert property ($rose(reset_n) |-> ##[1:2] powerLed)
      else $error("power indicator not lit after reset");
   AST_SUPPLY_LOSS: assert property (!ctrlSupplyOk |-> ##[1:3] !operational)
      else $error("operational without controller supply");
   AST_PUSH_PULSE: assert property (errStackPush[0] |=> !errStackPush[0])
      else $error("error entry longer than one cycle");
   AST_SHUT_HOLD: assert property (safeShutdown[0] |=> safeShutdown[0])
      else $error("safe shutdown released without reset");
   AST_ENTRY_STILL: assert property ($rose(errStackPush[0]) |-> ##[0:2] !standstillOut[0])
      else $error("standstill kept with error entry");
   AST_ENTRY_DIAG: assert property ($rose(errStackPush[0]) |-> ##[0:2] (diagWord0[9] || diagWord0[10]))
      else $error("error entry without diagnostic bit");
   AST_STILL_IND: assert property ($rose(standstillOut[0]) && diagWord0 == 16'h0000
      |-> ##[0:2] axis_one_state_indicator == 2'h1)
      else $error("axis indicator not showing standstill");
   AST_ENC_PORT: assert property (!encConnected[0] |-> ##[1:3] !axis_one_encoder_port)
      else $error("encoder port lit without encoder");
endmodule : asp_monitor_props

bind asp_monitor asp_monitor_props i_asp_monitor_props (.*);

/* File: dv/asp_sensor_model.sv */
module asp_sensor_model (
   input wire logic mclk,
   input wire asp_pkg::asp_act_type act0,
   input wire asp_pkg::asp_act_type act1,
   output logic [1:0] encTrackA,
   output logic [1:0] encTrackB,
   output logic axis_one_prox_input_a,
   output logic axis_one_prox_input_b,
   output logic axis_two_prox_input_a,
   output logic axis_two_prox_input_b
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ph = 2'h0;
   // a stopped shaft holds its last level; all inputs toggle together
   // so no transient mixed state reaches the plausibility logic
   initial begin
      encTrackA = 2'h0;
      encTrackB = 2'h0;
      axis_one_prox_input_a = 1'b0;
      axis_two_prox_input_a = 1'b0;
   end
   always @(negedge mclk) begin
      ph <= ph + 2'h1;
      if (ph == 2'h0) begin
         encTrackA <= encTrackA ^ {act1.trackA, act0.trackA};
         encTrackB <= encTrackB ^ {act1.trackB, act0.trackB};
         axis_one_prox_input_a <= axis_one_prox_input_a ^ act0.prox;
         axis_two_prox_input_a <= axis_two_prox_input_a ^ act1.prox;
      end
   end
   // second switch unused in mixed mode
   assign axis_one_prox_input_b = 1'b0;
   assign axis_two_prox_input_b = 1'b0;
endmodule : asp_sensor_model

/* File: dv/asp_monitor_tb.sv */
module asp_monitor_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, reset_n, cfgValid, shearpinEnable, internalFault, ctrlSupplyOk, ctrlRunOk;
   logic [1:0] axisMode0, axisMode1, encTrackA, encTrackB, encConnected, overspeed, dirRaw;
   logic axis_one_prox_input_a, axis_one_prox_input_b, axis_two_prox_input_a;
   logic axis_two_prox_input_b, monitorActive, operational, powerLed, faultLed;
   logic axis_one_encoder_port, axis_two_encoder_port;
   logic [31:0] activityWindow;
   logic [1:0] standstillOut, speedOut, directionOut, directionValid, errStackPush, safeShutdown;
   logic [1:0] axis_one_state_indicator, axis_two_state_indicator;
   logic [15:0] diagWord0, diagWord1;
   logic [3:0] proxLed;
   asp_pkg::asp_act_type act0, act1;
   int n_fail, checks_done;
   int pushCnt [2];
   logic anyEnt;

   asp_monitor i_asp_monitor (.*);
   asp_sensor_model i_asp_sensor_model (.*);

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      for (int k = 0; k < 2; k++) if (errStackPush[k] === 1'b1) pushCnt[k]++;
   end

   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr_next

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out

   task automatic check_axis(input int ax, input asp_pkg::asp_act_type c);
      logic b2, ent, still, ov, rot;
      logic [15:0] dw;
      logic [1:0] ind;
      ov = overspeed[ax];
      dw = (ax == 0) ? diagWord0 : diagWord1;
      ind = (ax == 0) ? axis_one_state_indicator : axis_two_state_indicator;
      // encoder-only axis: third input follows both tracks
      if (ax == 1 && axisMode1 == asp_pkg::MODE_ENCODER) c = {c[2], c[1], c[2] & c[1]};
      b2 = (c == 3'b001) && shearpinEnable;
      ent = b2 || (c inside {3'b011, 3'b101, 3'b110});
      still = (c inside {3'b000, 3'b001, 3'b010, 3'b100}) && !b2;
      rot = c inside {3'b011, 3'b101, 3'b110, 3'b111};
      anyEnt = anyEnt | ent;
      check("standstill", 16'(still), 16'(standstillOut[ax]));
      // speed follows the limit while rotating
      check("speed", 16'(b2 ? 1'b0 : (rot ? !ov : 1'b1)), 16'(speedOut[ax]));
      // direction passes, held invalid after a fault
      check("direction", 16'(dirRaw[ax]), 16'(directionOut[ax]));
      check("direction valid", 16'(!ent), 16'(directionValid[ax]));
      check("diag 9", 16'(c == 3'b001 || c == 3'b110), 16'(dw[9]));
      check("diag 10", 16'(c == 3'b011 || c == 3'b101), 16'(dw[10]));
      check("entry", 16'(ent), 16'(pushCnt[ax] > 0));
      if (b2) check("shutdown", 16'h0001, 16'(safeShutdown[ax]));
      if (c == 3'b000) check("indicator", 16'h0001, 16'(ind));
      if (c == 3'b111) check("indicator", 16'({ov, 1'b0}), 16'(ind));
      // port indicator, flash starts in its off phase
      check("port", 16'(encConnected[ax] && !ent),
         16'(ax == 0 ? axis_one_encoder_port : axis_two_encoder_port));
   endtask : check_axis

   task automatic run_case(input logic sh, input asp_pkg::asp_act_type c0,
         input asp_pkg::asp_act_type c1, input logic [7:0] r);
      @(negedge mclk);
      reset_n = 1'b0;
      cfgValid = 1'b0;
      act0 = '0;
      act1 = '0;
      shearpinEnable = sh;
      {ctrlSupplyOk, ctrlRunOk, encConnected, overspeed, dirRaw} = r;
      repeat (6) @(negedge mclk);
      reset_n = 1'b1;
      repeat (2) @(negedge mclk);
      cfgValid = 1'b1;
      repeat (4) @(negedge mclk);
      check("unloaded", 16'h0000, 16'(standstillOut));
      repeat (20) @(negedge mclk);
      pushCnt = '{0, 0};
      anyEnt = 1'b0;
      act0 = c0;
      act1 = c1;
      repeat (30) @(negedge mclk);
      check("operational", 16'(ctrlSupplyOk & ctrlRunOk), 16'(operational));
      check_axis(0, c0);
      check_axis(1, c1);
      // steady fault indicator on external fault
      check("fault led", 16'(anyEnt), 16'(faultLed));
      check("prox leds", 16'({axis_two_prox_input_b, axis_two_prox_input_a,
         axis_one_prox_input_b, axis_one_prox_input_a}), 16'(proxLed));
   endtask : run_case

   initial begin
      logic [7:0] rnd;
      rnd = 8'h1C;
      n_fail = 0;
      checks_done = 0;
      pushCnt = '{0, 0};
      axisMode0 = asp_pkg::MODE_MIXED;
      axisMode1 = asp_pkg::MODE_MIXED;
      activityWindow = 32'h00000008;
      internalFault = 1'b0;
      reset_n = 1'b0;
      cfgValid = 1'b0;
      shearpinEnable = 1'b0;
      act0 = '0;
      act1 = '0;
      {ctrlSupplyOk, ctrlRunOk, encConnected, overspeed, dirRaw} = 8'h00;
      for (int i = 0; i < 16; i++) begin
         rnd = lfsr_next(rnd);
         axisMode1 = i[0] ? asp_pkg::MODE_ENCODER : asp_pkg::MODE_MIXED;
         run_case(i[3], asp_pkg::asp_act_type'(i[2:0]), asp_pkg::asp_act_type'(rnd[2:0]), rnd);
      end
      close_out();
   end

   // a run still going after 3000 clock cycles ends here as a failure
   initial begin
      repeat (3000) @(posedge mclk);
      n_fail++;
      close_out();
   end
endmodule : asp_monitor_tb
